// ---- design/flow_defs.svh ----
// Constants for the program-flow and system-control execute block.
`ifndef FLOW_DEFS_SVH
`define FLOW_DEFS_SVH
`define OPC_CALL      4'h9
`define OPC_POP_WITH_LITERAL      4'h8
`define OPC_JMP       3'h5
`define OPC_RET       12'h00C
`define OPC_POP_WITH_PAGE_RESTORE      12'h00D
`define OPC_INTERRUPT_EXIT      12'h00E
`define OPC_INTERRUPT_EXIT_ADD_TIMER     12'h00F
`define OPC_SLEEP     12'h003
`define OPC_PROGRAM_MEMORY_FETCH     12'h041
`define OPC_BANK      9'h003
`define OPC_PAGE      9'h002
`define OPC_BITCLR    4'h4
`define OPC_SKIPCLR   4'h6
`define OPC_SKIPSET   4'h7
`define OPC_MOVFW     7'h01
`define OPC_ADDFW     7'h0F
`define ADDR_STATUS   5'h03
`define ADDR_PC       5'h02
`define BIT_CARRY     3'h0
`define BIT_PC_LSB    3'h0
`define BIT_TIMEOUT   4
`define BIT_POWERDOWN 3
`define CYC_LONG_SLOW 5'h08
`define CYC_LONG_TURBO 5'h03
`define CYC_ONE_SLOW  5'h04
`define CYC_ONE_TURBO 5'h01
`define CYC_RD_SLOW   5'h10
`define CYC_RD_TURBO  5'h04
`define CYC_IND_SLOW  5'h04
`define CYC_IND_TURBO 5'h03
`define CYC_SKIP_SLOW 5'h04
`define CYC_SKIP_TURBO 5'h02
`define CYC_BIT       5'h01
`define CYC_SKIPPED   5'h02
`define STACK_DEPTH   8
`endif

// ---- design/flow_pkg.sv ----
// Types shared by the program-flow execute block.
package flow_pkg;
  typedef struct packed {
    logic [7:0]  acc;
    logic [7:0]  status;
    logic [7:0]  file_select_pointer;
    logic [10:0] pc;
  } core_state_t;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_BUSY  = 3'b010,
    ST_FETCH = 3'b100
  } exec_state_t;
endpackage : flow_pkg

// ---- design/cycle_timer.sv ----
// Down counter that holds the core busy for an instruction's cycle count.
`timescale 1ns/1ps
`default_nettype none
module cycle_timer
  import flow_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       load,
  input  wire logic [4:0] count,
  output logic            done
);
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = count - 5'h01;
    end else if (cnt_q != 5'h00) begin
      cnt_d = cnt_q - 5'h01;
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= 5'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  // Done is high in the last cycle of the instruction.
  assign done = !load && (cnt_q == 5'h01 || cnt_q == 5'h00);
endmodule : cycle_timer
`default_nettype wire

// ---- design/program_flow_system_ops.sv ----
// Execute logic for program-control and system-control instructions.
`timescale 1ns/1ps
`default_nettype none
`include "flow_defs.svh"
module program_flow_system_ops
  import flow_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        turbo,
  input  wire logic        instr_valid,
  input  wire logic [11:0] instr,
  input  wire core_state_t core_in,
  input  wire core_state_t shadow_in,
  input  wire logic [3:0]  mode_in,
  input  wire logic        prescaler_to_watchdog,
  input  wire logic [11:0] progmem_rdata,
  output core_state_t      core_out,
  output logic [3:0]       mode_out,
  output logic             core_write,
  output logic             instr_ready,
  output logic             skip_next,
  output logic [10:0]      progmem_addr,
  output logic             progmem_rd,
  output logic [7:0]       realtime_add,
  output logic             realtime_add_en,
  output logic             watchdog_clear,
  output logic             prescaler_clear,
  output logic             osc_stop,
  output logic [2:0]       stack_level
);
  exec_state_t         st_q, st_d;
  core_state_t         out_q, out_d;
  logic [3:0]          mode_q, mode_d;
  logic                wr_q, wr_d, skip_q, skip_d;
  logic [10:0]         pa_q, pa_d;
  logic                rd_q, rd_d;
  logic [7:0]          rtadd_q, rtadd_d;
  logic                rten_q, rten_d, wdc_q, wdc_d, psc_q, psc_d, osc_q, osc_d;
  logic [2:0]          sp_q, sp_d;
  logic                rdy_q, rdy_d;
  logic [10:0]         stack_q [`STACK_DEPTH];
  logic [10:0]         stack_d [`STACK_DEPTH];
  logic                load;
  logic [4:0]          count;
  logic                done;

  function automatic logic [4:0] cyc(input logic t, input logic [4:0] s, input logic [4:0] f);
    cyc = t ? f : s;
  endfunction : cyc

  function automatic logic [10:0] top_of(input logic [2:0] sp);
    top_of = stack_q[sp - 3'h1];
  endfunction : top_of

  cycle_timer u_timer (
    .mclk  (mclk),
    .rst   (rst),
    .load  (load),
    .count (count),
    .done  (done)
  );

  always_comb begin
    logic [10:0] tos;
    logic [2:0]  sp_pop;
    logic        bit_val;
    tos     = top_of(sp_q);
    sp_pop  = sp_q - 3'h1;
    bit_val = core_in.status[instr[7:5]];
    st_d    = st_q;
    out_d   = out_q;
    mode_d  = mode_q;
    wr_d    = 1'b0;
    skip_d  = 1'b0;
    pa_d    = pa_q;
    rd_d    = 1'b0;
    rtadd_d = rtadd_q;
    rten_d  = 1'b0;
    wdc_d   = 1'b0;
    psc_d   = 1'b0;
    osc_d   = osc_q;
    sp_d    = sp_q;
    stack_d = stack_q;
    load    = 1'b0;
    count   = `CYC_ONE_SLOW;
    unique case (st_q)
      ST_IDLE: begin
        if (instr_valid) begin
          out_d  = core_in;
          mode_d = mode_in;
          load   = 1'b1;
          st_d   = ST_BUSY;
          count  = cyc(turbo, `CYC_ONE_SLOW, `CYC_ONE_TURBO);
          out_d.pc = core_in.pc + 11'h001;
          if (instr[11:8] == `OPC_CALL) begin
            stack_d[sp_q] = core_in.pc + 11'h001;
            sp_d = sp_q + 3'h1;
            out_d.pc = {core_in.status[6:5], 1'b0, instr[7:0]};
            count = cyc(turbo, `CYC_LONG_SLOW, `CYC_LONG_TURBO);
          end else if (instr[11:9] == `OPC_JMP) begin
            out_d.pc = {core_in.status[6:5], instr[8:0]};
            count = cyc(turbo, `CYC_LONG_SLOW, `CYC_LONG_TURBO);
          end else if (instr[11:8] == `OPC_POP_WITH_LITERAL) begin
            out_d.pc = tos;
            out_d.acc = instr[7:0];
            sp_d = sp_pop;
            count = cyc(turbo, `CYC_LONG_SLOW, `CYC_LONG_TURBO);
          end else if (instr == `OPC_RET) begin
            out_d.pc = tos;
            sp_d = sp_pop;
            count = cyc(turbo, `CYC_LONG_SLOW, `CYC_LONG_TURBO);
          end else if (instr == `OPC_POP_WITH_PAGE_RESTORE) begin
            out_d.pc = tos;
            out_d.status[6:5] = tos[10:9];
            sp_d = sp_pop;
            count = cyc(turbo, `CYC_LONG_SLOW, `CYC_LONG_TURBO);
          end else if (instr == `OPC_INTERRUPT_EXIT || instr == `OPC_INTERRUPT_EXIT_ADD_TIMER) begin
            out_d = shadow_in;
            out_d.status[`BIT_TIMEOUT] = core_in.status[`BIT_TIMEOUT];
            out_d.status[`BIT_POWERDOWN] = core_in.status[`BIT_POWERDOWN];
            if (instr == `OPC_INTERRUPT_EXIT_ADD_TIMER) begin
              rtadd_d = core_in.acc;
              rten_d  = 1'b1;
            end
            count = cyc(turbo, `CYC_LONG_SLOW, `CYC_LONG_TURBO);
          end else if (instr[11:3] == `OPC_BANK) begin
            out_d.file_select_pointer[7:5] = instr[2:0];
          end else if (instr[11:3] == `OPC_PAGE) begin
            out_d.status[7:5] = instr[2:0];
          end else if (instr == `OPC_SLEEP) begin
            wdc_d = 1'b1;
            out_d.status[`BIT_TIMEOUT] = 1'b1;
            out_d.status[`BIT_POWERDOWN] = 1'b0;
            psc_d = prescaler_to_watchdog;
            osc_d = 1'b1;
          end else if (instr == `OPC_PROGRAM_MEMORY_FETCH) begin
            pa_d = {mode_in[2:0], core_in.acc};
            rd_d = 1'b1;
            count = cyc(turbo, `CYC_RD_SLOW, `CYC_RD_TURBO);
            st_d = ST_FETCH;
          end else if (instr[11:8] == `OPC_BITCLR && instr[4:0] == `ADDR_STATUS) begin
            out_d.status[instr[7:5]] = 1'b0;
            count = `CYC_BIT;
          end else if ((instr[11:5] == `OPC_MOVFW || instr[11:5] == `OPC_ADDFW) && instr[4:0] == `ADDR_PC) begin
            // Only the low eight counter bits come from the accumulator.
            out_d.pc = {core_in.status[6:5], 1'b0,
                        instr[11:5] == `OPC_MOVFW ? core_in.acc : core_in.pc[7:0] + core_in.acc};
            count = cyc(turbo, `CYC_IND_SLOW, `CYC_IND_TURBO);
          end else if (instr[11:8] == `OPC_SKIPSET || instr[11:8] == `OPC_SKIPCLR) begin
            if (instr[4:0] == `ADDR_PC && instr[7:5] == `BIT_PC_LSB) begin
              skip_d = 1'b1;
              out_d.pc = core_in.pc + 11'h002;
              count = cyc(turbo, `CYC_SKIP_SLOW, `CYC_SKIP_TURBO);
            end else if (instr[4:0] == `ADDR_STATUS) begin
              skip_d = (bit_val == instr[8]);
              out_d.pc = core_in.pc + ((bit_val == instr[8]) ? 11'h002 : 11'h001);
              count = (bit_val == instr[8]) ? `CYC_SKIPPED : `CYC_BIT;
            end
          end
          // A one-cycle instruction commits at once, else the timer would stretch it to two.
          if (count == `CYC_BIT) begin
            wr_d = 1'b1;
            st_d = ST_IDLE;
          end
        end
      end
      ST_FETCH: begin
        if (done) begin
          out_d.acc = progmem_rdata[7:0];
          mode_d    = progmem_rdata[11:8];
          wr_d      = 1'b1;
          st_d      = ST_IDLE;
        end
      end
      ST_BUSY: begin
        // Results are committed on the last cycle so timing matches the core.
        if (done) begin
          wr_d = 1'b1;
          st_d = ST_IDLE;
        end
        skip_d = skip_q && !done;
      end
      default: st_d = ST_IDLE;
    endcase
    rdy_d = (st_d == ST_IDLE);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q    <= ST_IDLE;
      out_q   <= '0;
      mode_q  <= 4'h0;
      wr_q    <= 1'b0;
      skip_q  <= 1'b0;
      pa_q    <= 11'h000;
      rd_q    <= 1'b0;
      rtadd_q <= 8'h00;
      rten_q  <= 1'b0;
      wdc_q   <= 1'b0;
      psc_q   <= 1'b0;
      osc_q   <= 1'b0;
      sp_q    <= 3'h0;
      rdy_q   <= 1'b1;
      for (int i = 0; i < `STACK_DEPTH; i++) begin
        stack_q[i] <= 11'h000;
      end
    end else begin
      st_q    <= st_d;
      out_q   <= out_d;
      mode_q  <= mode_d;
      wr_q    <= wr_d;
      skip_q  <= skip_d;
      pa_q    <= pa_d;
      rd_q    <= rd_d;
      rtadd_q <= rtadd_d;
      rten_q  <= rten_d;
      wdc_q   <= wdc_d;
      psc_q   <= psc_d;
      osc_q   <= osc_d;
      sp_q    <= sp_d;
      rdy_q   <= rdy_d;
      stack_q <= stack_d;
    end
  end

  assign core_out        = out_q;
  assign mode_out        = mode_q;
  assign core_write      = wr_q;
  assign instr_ready     = rdy_q;
  assign skip_next       = skip_q;
  assign progmem_addr    = pa_q;
  assign progmem_rd      = rd_q;
  assign realtime_add    = rtadd_q;
  assign realtime_add_en = rten_q;
  assign watchdog_clear  = wdc_q;
  assign prescaler_clear = psc_q;
  assign osc_stop        = osc_q;
  assign stack_level     = sp_q;
endmodule : program_flow_system_ops
`default_nettype wire

// ---- dv/flow_props.sv ----
// Concurrent checks on the ports of the program-flow execute block.
`timescale 1ns/1ps
`default_nettype none
module flow_props
  import flow_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        turbo,
  input wire logic        instr_valid,
  input wire logic [11:0] instr,
  input wire core_state_t core_in,
  input wire logic [3:0]  mode_in,
  input wire logic        prescaler_to_watchdog,
  input wire core_state_t core_out,
  input wire logic        core_write,
  input wire logic        instr_ready,
  input wire logic [10:0] progmem_addr,
  input wire logic        progmem_rd,
  input wire logic [7:0]  realtime_add,
  input wire logic        realtime_add_en,
  input wire logic        watchdog_clear,
  input wire logic        prescaler_clear,
  input wire logic        osc_stop,
  input wire logic [2:0]  stack_level
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire tk = instr_valid && instr_ready;
  sequence three_s;
    !core_write ##1 !core_write ##1 core_write;
  endsequence
  a_call_turbo_time: assert property (tk && turbo && instr[11:8] == 4'h9 |=> three_s)
    else $error("call did not end after three cycles");
  a_call_stack_push: assert property (tk && instr[11:8] == 4'h9 |=> stack_level == $past(stack_level) + 3'h1)
    else $error("call did not push the stack");
  a_jump_slow_time: assert property (tk && !turbo && instr[11:9] == 3'h5 |=>
    !core_write [*7] ##1 core_write && core_out.pc[8:0] == $past(instr[8:0], 8))
    else $error("slow jump timing or target wrong");
  a_exit_keeps_flags: assert property (tk && turbo && instr == 12'h00E |=>
    ##2 core_write && core_out.status[4:3] == $past(core_in.status[4:3], 3))
    else $error("interrupt exit changed timeout or powerdown");
  a_timer_add_acc: assert property (tk && instr == 12'h00F |=> realtime_add_en &&
    realtime_add == $past(core_in.acc))
    else $error("timer exit did not add the accumulator");
  a_fetch_address: assert property (tk && instr == 12'h041 |=> progmem_rd &&
    progmem_addr == {$past(mode_in[2:0]), $past(core_in.acc)})
    else $error("fetch address wrong");
  a_sleep_side_pulses: assert property (tk && instr == 12'h003 |=> watchdog_clear &&
    prescaler_clear == $past(prescaler_to_watchdog) ##1 osc_stop)
    else $error("sleep side effects wrong");
  a_bank_one_cycle: assert property (tk && turbo && instr[11:3] == 9'h003 |=> core_write &&
    core_out.file_select_pointer[7:5] == $past(instr[2:0]))
    else $error("bank select wrong");
endmodule : flow_props
bind program_flow_system_ops flow_props flow_props_inst (
  .mclk                  (mclk),
  .rst                   (rst),
  .turbo                 (turbo),
  .instr_valid           (instr_valid),
  .instr                 (instr),
  .core_in               (core_in),
  .mode_in               (mode_in),
  .prescaler_to_watchdog (prescaler_to_watchdog),
  .core_out              (core_out),
  .core_write            (core_write),
  .instr_ready           (instr_ready),
  .progmem_addr          (progmem_addr),
  .progmem_rd            (progmem_rd),
  .realtime_add          (realtime_add),
  .realtime_add_en       (realtime_add_en),
  .watchdog_clear        (watchdog_clear),
  .prescaler_clear       (prescaler_clear),
  .osc_stop              (osc_stop),
  .stack_level           (stack_level)
);
`default_nettype wire

// ---- dv/tb_program_flow_system_ops.sv ----
// Self-checking bench for the program-flow execute block.
`timescale 1ns/1ps
`default_nettype none
module tb_program_flow_system_ops
  import flow_pkg::*;
;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        turbo = 1'b0;
  logic        instr_valid = 1'b0;
  logic [11:0] instr = 12'h000;
  core_state_t core_in = '{8'h5A, 8'h79, 8'h1F, 11'h123};
  core_state_t shadow_in = '{8'hA5, 8'h06, 8'h33, 11'h456};
  logic [3:0]  mode_in = 4'h3;
  logic        prescaler_to_watchdog = 1'b1;
  logic [11:0] progmem_rdata = 12'hC3E;
  core_state_t core_out;
  logic [3:0]  mode_out;
  logic        core_write, instr_ready, skip_next, progmem_rd, realtime_add_en;
  logic        watchdog_clear, prescaler_clear, osc_stop;
  logic [10:0] progmem_addr;
  logic [7:0]  realtime_add;
  logic [2:0]  stack_level;
  logic        sk;
  logic [4:0]  side;
  logic [7:0]  rt;
  logic [10:0] pma;
  int          n;
  int          err_total = 0;
  int          num_checks = 0;
  program_flow_system_ops program_flow_system_ops_inst (
    .mclk                  (mclk),
    .rst                   (rst),
    .turbo                 (turbo),
    .instr_valid           (instr_valid),
    .instr                 (instr),
    .core_in               (core_in),
    .shadow_in             (shadow_in),
    .mode_in               (mode_in),
    .prescaler_to_watchdog (prescaler_to_watchdog),
    .progmem_rdata         (progmem_rdata),
    .core_out              (core_out),
    .mode_out              (mode_out),
    .core_write            (core_write),
    .instr_ready           (instr_ready),
    .skip_next             (skip_next),
    .progmem_addr          (progmem_addr),
    .progmem_rd            (progmem_rd),
    .realtime_add          (realtime_add),
    .realtime_add_en       (realtime_add_en),
    .watchdog_clear        (watchdog_clear),
    .prescaler_clear       (prescaler_clear),
    .osc_stop              (osc_stop),
    .stack_level           (stack_level)
  );
  always #12.5 mclk = ~mclk;
  task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Counts edges from the take, which counts as one, to the commit; a missing commit stops at 40.
  task automatic exec(input logic [11:0] op, input logic t);
    @(negedge mclk);
    instr = op;
    turbo = t;
    instr_valid = 1'b1;
    @(posedge mclk);
    #1;
    n = 1;
    sk = (skip_next === 1'b1);
    side = {instr_ready, progmem_rd, watchdog_clear, prescaler_clear, realtime_add_en};
    rt = realtime_add;
    pma = progmem_addr;
    @(negedge mclk);
    instr_valid = 1'b0;
    while (core_write !== 1'b1 && n < 40) begin
      @(posedge mclk);
      #1;
      n++;
      sk = sk | (skip_next === 1'b1);
    end
  endtask : exec
  task automatic t_flow();
    exec(12'h9AB, 1'b1);
    check("call cyc", 11'(n), 11'd3);
    check("call pc", core_out.pc, {2'b11, 1'b0, 8'hAB});
    check("stack", 11'(stack_level), 11'd1);
    exec(12'h9AB, 1'b0);
    check("call slow", 11'(n), 11'd8);
    exec(12'hB55, 1'b0);
    check("jump pc", core_out.pc, {2'b11, 9'h155});
    exec(12'hB55, 1'b1);
    check("jump cyc", 11'(n), 11'd3);
    exec(12'h00C, 1'b1);
    check("ret cyc", 11'(n), 11'd3);
    check("ret pc", core_out.pc, 11'h124);
    check("ret st", 11'(core_out.status), 11'h079);
    exec(12'h00D, 1'b0);
    check("pop_with_page_restore cyc", 11'(n), 11'd8);
    check("pop_with_page_restore pc", core_out.pc, 11'h124);
    check("pop_with_page_restore page", 11'(core_out.status[6:5]), 11'h0);
    exec(12'h9AB, 1'b1);
    exec(12'h8C7, 1'b1);
    check("pop_with_literal cyc", 11'(n), 11'd3);
    check("pop_with_literal pc", core_out.pc, 11'h124);
    check("pop_with_literal acc", 11'(core_out.acc), 11'h0C7);
    $display("flow test done");
  endtask : t_flow
  task automatic t_exit();
    exec(12'h00E, 1'b1);
    check("exit acc", 11'(core_out.acc), 11'h0A5);
    check("exit fsr", 11'(core_out.file_select_pointer), 11'h033);
    check("exit pc", core_out.pc, 11'h456);
    check("exit st", 11'(core_out.status), 11'h01E);
    check("exit side", 11'(side), 11'h000);
    exec(12'h00F, 1'b1);
    check("exitw pc", core_out.pc, 11'h456);
    check("exitw st", 11'(core_out.status), 11'h01E);
    check("exitw en", 11'(side), 11'h001);
    check("exitw add", 11'(rt), 11'h05A);
    $display("exit test done");
  endtask : t_exit
  task automatic t_select();
    exec(12'h01D, 1'b1);
    check("bank cyc", 11'(n), 11'd1);
    check("bank fsr", 11'(core_out.file_select_pointer), 11'h0BF);
    exec(12'h01D, 1'b0);
    check("bank slow", 11'(n), 11'd4);
    exec(12'h016, 1'b1);
    check("page st", 11'(core_out.status[7:5]), 11'h6);
    exec(12'h016, 1'b0);
    check("page slow", 11'(n), 11'd4);
    exec(12'h041, 1'b1);
    check("fetch cyc", 11'(n), 11'd4);
    check("fetch mode", 11'(mode_out), 11'h00C);
    check("fetch acc", 11'(core_out.acc), 11'h03E);
    check("fetch rd", 11'(side), 11'h008);
    check("fetch addr", pma, 11'h35A);
    exec(12'h041, 1'b0);
    check("fetch slow", 11'(n), 11'd16);
    $display("select test done");
  endtask : t_select
  task automatic t_alias();
    exec(12'h403, 1'b1);
    check("clc cyc", 11'(n), 11'd1);
    check("clc st", 11'(core_out.status[0]), 11'h0);
    exec(12'h022, 1'b0);
    check("ind slow", 11'(n), 11'd4);
    check("ind pc", 11'(core_out.pc[7:0]), 11'h05A);
    exec(12'h1E2, 1'b1);
    check("ind cyc", 11'(n), 11'd3);
    exec(12'h703, 1'b1);
    check("sc skip", {n[9:0], sk}, {10'd2, 1'b1});
    @(negedge mclk);
    core_in.status = 8'h78;
    exec(12'h703, 1'b1);
    check("sc none", {n[9:0], sk}, {10'd1, 1'b0});
    exec(12'h702, 1'b0);
    check("skip slow", {n[9:0], sk}, {10'd4, 1'b1});
    exec(12'h702, 1'b1);
    check("skip cyc", {n[9:0], sk}, {10'd2, 1'b1});
    $display("alias test done");
  endtask : t_alias
  // Sleep runs last because the oscillator stop holds until reset.
  task automatic t_sleep();
    exec(12'h003, 1'b1);
    check("sleep cyc", 11'(n), 11'd1);
    check("sleep st", 11'(core_out.status[4:3]), 11'h2);
    check("osc stop", 11'(osc_stop), 11'h1);
    check("sleep side", 11'(side), 11'h016);
    $display("sleep test done");
  endtask : t_sleep
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    #(25 * 3000);
    err_total++;
    end_of_test();
  end
  initial begin
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    t_flow();
    t_exit();
    t_select();
    t_alias();
    t_sleep();
    end_of_test();
  end
endmodule : tb_program_flow_system_ops
`default_nettype wire
